// ---- verilog/sdio_top.sv ----
// Data and parity lane direction, capture and self-timed write control
// Function
// RQ1: OE low drives read data if selected
// RQ2: OE high three-states all lanes
// RQ3: Sixteen data lines, upper and lower halves
// RQ4: Pins captured into data register each edge; the code holds a half's register while that half drives
// RQ5: Half three-stated when its write strobe low
// RQ6: Two parity lines follow their half
// RQ7: Self-timed half write, ignored with strobe+select
// RQ8: Master avoids driving while device drives
`timescale 1ns/1ns
module sdio_top
	import sdio_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              RST_N,
	input  wire logic              OE_N,
	input  wire logic              CS_N,
	input  wire logic              PROC_ADDR_STROBE_N,
	input  wire logic              UPPER_HALF_WRITE_N,
	input  wire logic              LOWER_HALF_WRITE_N,
	input  wire logic [ADDR_W-1:0] ADDR,
	input  wire logic [DATA_W-1:0] DQ_IN,
	output logic      [DATA_W-1:0] DQ_OUT,
	output logic      [DATA_W-1:0] DQ_OE,
	input  wire logic [PAR_W-1:0]  PARITY_LANES_IN,
	output logic      [PAR_W-1:0]  PARITY_LANES_OUT,
	output logic      [PAR_W-1:0]  PARITY_LANES_OE
);
	sdio_mem_if mem_if ();

	// Write phase of one half
	typedef enum logic [1:0] {
		WR_IDLE   = 2'h1,
		WR_COMMIT = 2'h2
	} sdio_wr_state_t;

	// Lane of one half: parity bit above its eight data bits
	function automatic sdio_lane_t lane_of(
		input logic [DATA_W-1:0] dq,
		input logic [PAR_W-1:0]  dp,
		input int                h
	);
		lane_of = {dp[h], dq[h*HALF_DATA_W +: HALF_DATA_W]};
	endfunction

	// Processor strobe seen together with select
	function automatic logic proc_cycle(
		input logic cs_n,
		input logic ads_n
	);
		proc_cycle = !cs_n && !ads_n;
	endfunction

	// Half drives only when enabled, selected and not written
	function automatic logic half_drive(
		input logic oe_n,
		input logic sel,
		input logic wr_low
	);
		half_drive = !oe_n && sel && !wr_low;
	endfunction

	// Combinational decodes
	sdio_halves_t   strobe_n;
	sdio_halves_t   drive;
	sdio_halves_t   wr_taken;
	logic           proc_seen;

	// Registered controls and their next values
	sdio_addr_t     addr_ff;
	sdio_addr_t     nxt_addr;
	logic           sel_ff;
	logic           nxt_sel;
	sdio_halves_t   wr_low_ff;
	sdio_halves_t   nxt_wr_low;
	sdio_wr_state_t wr_state_ff  [NUM_HALVES];
	sdio_wr_state_t nxt_wr_state [NUM_HALVES];
	sdio_lane_t     din_ff       [NUM_HALVES];
	sdio_lane_t     nxt_din      [NUM_HALVES];
	sdio_lane_t     rd_lane      [NUM_HALVES];

	// Strobes gathered by half index
	assign strobe_n[HALF_UPPER] = UPPER_HALF_WRITE_N;
	assign strobe_n[HALF_LOWER] = LOWER_HALF_WRITE_N;

	// Processor strobe with select: loads address, blocks writes
	assign proc_seen = proc_cycle(CS_N, PROC_ADDR_STROBE_N);

	// Address register, loaded only by a selected processor strobe
	always_comb begin
		nxt_addr = addr_ff;
		if (proc_seen) begin
			nxt_addr = ADDR;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			addr_ff <= ADDR_RST;
		end else begin
			addr_ff <= nxt_addr;
		end
	end

	// Select sampled at the start of each cycle
	always_comb begin
		nxt_sel = !CS_N; // RQ1
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sel_ff <= 1'h0;
		end else begin
			sel_ff <= nxt_sel;
		end
	end

	// Write strobes sampled low three-state their half
	always_comb begin
		nxt_wr_low = ~strobe_n; // RQ5
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wr_low_ff <= HALVES_RST;
		end else begin
			wr_low_ff <= nxt_wr_low;
		end
	end

	// Strobe ignored when processor strobe and select coincide
	always_comb begin
		for (int k = 0; k < NUM_HALVES; k++) begin
			wr_taken[k] = !strobe_n[k] && !proc_seen; // RQ7
		end
	end

	// One copy of the lane logic per half
	genvar h;
	generate
		for (h = 0; h < NUM_HALVES; h++) begin : g_capture
			// Async OE: direction follows the pin without a clock
			assign drive[h] =
				half_drive(OE_N, sel_ff, wr_low_ff[h]); // RQ1 RQ2 RQ5

			// Data register takes the pins while they act as inputs
			always_comb begin
				nxt_din[h] = din_ff[h];
				if (!drive[h]) begin
					nxt_din[h] =
						lane_of(DQ_IN, PARITY_LANES_IN, h); // RQ4 RQ6
				end
			end

			always_ff @(posedge CLK or negedge RST_N) begin
				if (!RST_N) begin
					din_ff[h] <= LANE_RST;
				end else begin
					din_ff[h] <= nxt_din[h];
				end
			end
		end

		for (h = 0; h < NUM_HALVES; h++) begin : g_write
			// Back-to-back writes are allowed, so commit may repeat
			always_comb begin
				nxt_wr_state[h] = WR_IDLE;
				unique case (wr_state_ff[h])
					WR_IDLE: begin
						if (wr_taken[h]) begin
							nxt_wr_state[h] = WR_COMMIT;
						end
					end
					WR_COMMIT: begin
						if (wr_taken[h]) begin
							nxt_wr_state[h] = WR_COMMIT;
						end
					end
					default: begin
						nxt_wr_state[h] = WR_IDLE;
					end
				endcase
			end

			always_ff @(posedge CLK or negedge RST_N) begin
				if (!RST_N) begin
					wr_state_ff[h] <= WR_IDLE;
				end else begin
					wr_state_ff[h] <= nxt_wr_state[h];
				end
			end

			// Self-timed write one cycle after the strobe edge
			assign mem_if.wr_en[h] =
				(wr_state_ff[h] == WR_COMMIT); // RQ7
			assign mem_if.wr_lane[h] = din_ff[h]; // RQ4
		end

		for (h = 0; h < NUM_HALVES; h++) begin : g_pins
			// Read lanes split back into data and parity pins
			assign rd_lane[h] = mem_if.rd_lane[h];
			assign DQ_OUT[h*HALF_DATA_W +: HALF_DATA_W] =
				rd_lane[h][HALF_DATA_W-1:0]; // RQ3
			assign PARITY_LANES_OUT[h] =
				rd_lane[h][HALF_DATA_W]; // RQ6
			assign DQ_OE[h*HALF_DATA_W +: HALF_DATA_W] =
				{HALF_DATA_W{drive[h]}}; // RQ2 RQ3
			// Parity pin shares its half's direction and strobe
			assign PARITY_LANES_OE[h] = drive[h]; // RQ6
		end
	endgenerate

	// Write address stays on the bus so the pending write lands there
	assign mem_if.addr = addr_ff;

	sdio_array u_array (
		.CLK    (CLK),
		.RST_N  (RST_N),
		.mem_if (mem_if)
	);
endmodule // sdio_top

// ---- verilog/sdio_pkg.sv ----
// Constants and types for the synchronous SRAM data I/O control block
package sdio_pkg;
	localparam int DATA_W      = 16;
	localparam int PAR_W       = 2;
	localparam int ADDR_W      = 16;
	localparam int HALF_DATA_W = 8;
	localparam int LANE_W      = 9;
	localparam int NUM_HALVES  = 2;
	localparam int HALF_LOWER  = 0;
	localparam int HALF_UPPER  = 1;

	typedef logic [LANE_W-1:0]     sdio_lane_t;
	typedef logic [ADDR_W-1:0]     sdio_addr_t;
	typedef logic [NUM_HALVES-1:0] sdio_halves_t;

	localparam sdio_lane_t   LANE_RST   = 9'h000;
	localparam sdio_addr_t   ADDR_RST   = 16'h0000;
	localparam sdio_halves_t HALVES_RST = 2'h0;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic [PAR_W-1:0]  PAR_RST  = 2'h0;
endpackage

// ---- verilog/sdio_mem_if.sv ----
// Carrier between the data I/O control and its storage array
`timescale 1ns/1ns
interface sdio_mem_if;
	import sdio_pkg::*;
	sdio_halves_t wr_en;
	sdio_addr_t   addr;
	sdio_lane_t   wr_lane [NUM_HALVES];
	sdio_lane_t   rd_lane [NUM_HALVES];

	modport ctrl (output wr_en, output addr, output wr_lane, input rd_lane);
	modport mem  (input wr_en, input addr, input wr_lane, output rd_lane);
endinterface

// ---- verilog/sdio_array.sv ----
// Two-half storage array with registered read data
`timescale 1ns/1ns
module sdio_array
	import sdio_pkg::*;
(
	input  wire logic CLK,
	input  wire logic RST_N,
	sdio_mem_if.mem   mem_if
);
	localparam int DEPTH = 2 ** ADDR_W;

	genvar h;
	generate
		for (h = 0; h < NUM_HALVES; h++) begin : g_half
			sdio_lane_t cells [DEPTH];
			sdio_lane_t rd_ff;
			sdio_lane_t nxt_rd;

			always_comb begin
				nxt_rd = cells[mem_if.addr];
			end

			// Array cells carry no reset
			always_ff @(posedge CLK) begin
				if (mem_if.wr_en[h]) begin
					cells[mem_if.addr] <= mem_if.wr_lane[h];
				end
			end

			always_ff @(posedge CLK or negedge RST_N) begin
				if (!RST_N) begin
					rd_ff <= LANE_RST;
				end else begin
					rd_ff <= nxt_rd;
				end
			end

			assign mem_if.rd_lane[h] = rd_ff;
		end
	endgenerate
endmodule // sdio_array

// ---- sim/sdio_top_monitor.sv ----
// Checker for lane direction control
`timescale 1ns/1ns
module sdio_top_monitor (
	input logic        CLK,
	input logic        RST_N,
	input logic        OE_N,
	input logic        CS_N,
	input logic        UPPER_HALF_WRITE_N,
	input logic        LOWER_HALF_WRITE_N,
	input logic [15:0] DQ_OE,
	input logic [1:0]  PARITY_LANES_OE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	a_oe_high_off: assert property (
		OE_N |-> !DQ_OE && !PARITY_LANES_OE) else $error("driven, OE high");
	a_read_drive: assert property (
		!CS_N && UPPER_HALF_WRITE_N && LOWER_HALF_WRITE_N ##1 !OE_N
		|-> &DQ_OE && &PARITY_LANES_OE) else $error("read not driven");
	a_desel_off: assert property (
		CS_N |=> !DQ_OE && !PARITY_LANES_OE) else $error("driven, deselected");
	a_upper_off: assert property (
		!UPPER_HALF_WRITE_N |=> !DQ_OE[15:8] && !PARITY_LANES_OE[1])
		else $error("upper driven in write");
	a_lower_off: assert property (
		!LOWER_HALF_WRITE_N |=> !DQ_OE[7:0] && !PARITY_LANES_OE[0])
		else $error("lower driven in write");
	a_data_halves: assert property (
		DQ_OE[15:8] inside {8'h00, 8'hFF} && DQ_OE[7:0] inside {8'h00, 8'hFF})
		else $error("half split");
	a_par_follow: assert property (
		PARITY_LANES_OE == {DQ_OE[8], DQ_OE[0]}) else $error("parity apart");
	cover property (!OE_N && DQ_OE[0]);
	cover property (!UPPER_HALF_WRITE_N);
	cover property (!LOWER_HALF_WRITE_N ##1 !OE_N);
endmodule // sdio_top_monitor

// ---- sim/sdio_master.sv ----
// Bus master model resolving the shared lanes
`timescale 1ns/1ns
module sdio_master (
	input  logic        drv,
	input  logic [17:0] dat,
	input  logic [17:0] oe,
	input  logic [17:0] dout,
	output logic [17:0] pin
);
	// Master drives dat only while device lanes are off and drv is set; pin takes dout while the device drives, else ~dout
	always_comb begin
		for (int i = 0; i < 18; i++)
			pin[i] = oe[i] ? dout[i] : (drv ? dat[i] : ~dout[i]);
	end
endmodule // sdio_master

// ---- sim/sdio_top_bench.sv ----
// Random write and read-back bench for lane control
`timescale 1ns/1ns
module sdio_top_bench;
	logic        clk = 0, rst_n = 0, oe_n = 1, cs_n = 1, ads_n = 1;
	logic        wu_n = 1, wl_n = 1, drv = 0, r, u, l;
	logic [15:0] addr = 0, pool [8];
	logic [17:0] dat = 0, pin, dout, oe;
	logic [17:0] mem [65536];
	int          miscompares = 0, check_count = 0;
	always #50 clk = ~clk;
	sdio_top i_sdio_top(.CLK(clk), .RST_N(rst_n), .OE_N(oe_n), .CS_N(cs_n),
		.PROC_ADDR_STROBE_N(ads_n), .UPPER_HALF_WRITE_N(wu_n),
		.LOWER_HALF_WRITE_N(wl_n), .ADDR(addr), .DQ_IN(pin[15:0]),
		.DQ_OUT(dout[15:0]), .DQ_OE(oe[15:0]),
		.PARITY_LANES_IN(pin[17:16]), .PARITY_LANES_OUT(dout[17:16]),
		.PARITY_LANES_OE(oe[17:16]));
	sdio_master i_sdio_master(.drv(drv), .dat(dat), .oe(oe), .dout(dout),
		.pin(pin));
	task cyc(input logic o, c, a, wu, wl, d);
		@(negedge clk);
		{oe_n, cs_n, ads_n, wu_n, wl_n, drv} = {o, c, a, wu, wl, d};
		@(posedge clk);
	endtask
	task chk(input logic [17:0] got, exp);
		check_count++;
		if (got !== exp || $isunknown(got)) begin
			miscompares++;
			$display("BAD %0t lanes %h exp %h", $time, got, exp);
		end
	endtask
	function logic [17:0] merge(input logic [17:0] o, d, input logic wu, wl);
		return {wu ? o[17] : d[17], wl ? o[16] : d[16],
			wu ? o[15:8] : d[15:8], wl ? o[7:0] : d[7:0]};
	endfunction
	task summarize;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hCE054EDF));
		foreach (pool[k])
			pool[k] = 16'($urandom);
		repeat (4) @(posedge clk);
		@(negedge clk) rst_n = 1;
		for (int i = 0; i < 40; i++) begin
			if (i == 20) begin
				// Mid-run reset clears select and read register
				@(negedge clk) {rst_n, oe_n} = 2'h0;
				#1 chk(oe, 18'h00000);
				chk(dout, 18'h00000);
				@(negedge clk) rst_n = 1;
			end
			@(negedge clk);
			addr = pool[i < 8 ? i : $urandom_range(7, 0)];
			dat = 18'($urandom);
			// First passes fill every pool word, never refused
			{r, u, l} = i < 8 ? 3'h4 : 3'($urandom);
			cyc(1, 0, 0, 1, 1, 1);
			cyc(1, 0, r, u, l, 1);
			if (r)
				mem[addr] = merge(mem[addr], dat, u, l);
			cyc(1, 0, 0, 1, 1, 0);
			cyc(0, 0, 1, 1, 1, 0);
			#1 chk(dout, mem[addr]);
			chk(oe, 18'h3FFFF);
			@(negedge clk) oe_n = 1;
			#1 chk(oe, 18'h00000);
			cyc(0, 1, 1, 1, 1, 0);
			#1 chk(oe, 18'h00000);
		end
		summarize();
	end
endmodule // sdio_top_bench
bind sdio_top sdio_top_monitor i_sdio_top_monitor(.CLK(CLK), .RST_N(RST_N),
	.OE_N(OE_N), .CS_N(CS_N), .UPPER_HALF_WRITE_N(UPPER_HALF_WRITE_N),
	.LOWER_HALF_WRITE_N(LOWER_HALF_WRITE_N), .DQ_OE(DQ_OE),
	.PARITY_LANES_OE(PARITY_LANES_OE));
